// File: asl_pkg.sv
// Package for the asynchronous serial loop/control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per byte
// address, data on the low lane.
package asl_pkg;

  // Register byte offsets from the block base
  localparam logic [2:0] ASL_IDX_CTRL_ONE  = 3'h0;
  localparam logic [2:0] ASL_IDX_BAUD      = 3'h1;
  localparam logic [2:0] ASL_IDX_DATA      = 3'h2;
  localparam logic [2:0] ASL_IDX_CTRL_TWO  = 3'h3;
  localparam logic [2:0] ASL_IDX_STAT_ONE  = 3'h4;
  localparam logic [2:0] ASL_IDX_STAT_TWO  = 3'h5;
  localparam logic [2:0] ASL_IDX_IRQ_MASK  = 3'h6;

  // serial_control_one fields
  localparam int ASL_C1_LOOP_BIT = 7;
  localparam int ASL_C1_RX_SOURCE_SEL_BIT = 5;

  // serial_control_two fields
  localparam int ASL_C2_TX_EMPTY_IE = 7;
  localparam int ASL_C2_TX_DONE_IE  = 6;
  localparam int ASL_C2_RX_FULL_IE  = 5;
  localparam int ASL_C2_IDLE_IE     = 4;
  localparam int ASL_C2_TX_ON       = 3;
  localparam int ASL_C2_RX_ON       = 2;
  localparam logic [7:0] ASL_C2_RW_MASK = 8'hFC;

  // serial_status_one: sticky event bits, write one to clear
  localparam int ASL_ST_TX_EMPTY = 4;
  localparam int ASL_ST_TX_DONE  = 3;
  localparam int ASL_ST_RX_FULL  = 2;
  localparam int ASL_ST_OVERRUN  = 1;
  localparam int ASL_ST_IDLE     = 0;
  localparam int ASL_NUM_EV      = 5;

  // serial_status_two fields
  localparam int ASL_S2_LINE_BIT = 7;
  localparam int ASL_S2_BUSY_BIT = 6;
  localparam int ASL_S2_DIR_BIT  = 1;

  // Reset values
  localparam logic [7:0]  ASL_C1_RST    = 8'h00;
  localparam logic [7:0]  ASL_C2_RST    = 8'h00;
  localparam logic [15:0] ASL_BAUD_RST  = 16'h01B2;
  localparam logic [4:0]  ASL_MASK_RST  = 5'h1F;
  localparam logic [9:0]  ASL_SH_IDLE   = 10'h3FF;

  // Frame shape: start, eight data, stop
  localparam logic [3:0] ASL_LAST_BIT   = 4'h9;
  localparam logic [3:0] ASL_STOP_BIT   = 4'h8;

  typedef enum logic [2:0] {
    ASL_TX_IDLE  = 3'b001,
    ASL_TX_SHIFT = 3'b010,
    ASL_TX_PRE   = 3'b100
  } asl_tx_st_t;

  typedef enum logic [2:0] {
    ASL_RX_IDLE  = 3'b001,
    ASL_RX_START = 3'b010,
    ASL_RX_DATA  = 3'b100
  } asl_rx_st_t;

endpackage

// File: asl_serial_ctrl.sv
// Control slice of an asynchronous serial unit: control registers, loop and
// single-wire routing, a small 8N1 transmitter and receiver, and interrupts.
// Assumes one 50 MHz clock, synchronous active-high reset, Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none

module asl_serial_ctrl
  import asl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // Serial pins
  input  wire logic        rxd_i,
  input  wire logic        txd_i,
  output var  logic        txd_o,
  output var  logic        txd_oe_n,
  // Interrupt
  output var  logic        irq
);

  typedef struct packed {
    logic                  wait_r;
    logic [31:0]           rdata;
    logic [7:0]            ctrl_one;
    logic [7:0]            ctrl_two;
    logic                  pin_dir;
    logic [15:0]           baud;
    logic [ASL_NUM_EV-1:0] status;
    logic [ASL_NUM_EV-1:0] mask;
    logic [1:0][2:0]       sync;
    logic [1:0]            filt;
    logic                  tx_on_d;
    logic                  pre_pend;
    logic [7:0]            tx_buf;
    logic                  tx_buf_full;
    asl_tx_st_t            tx_st;
    logic [9:0]            tx_sh;
    logic [15:0]           tx_cnt;
    logic [3:0]            tx_bits;
    asl_rx_st_t            rx_st;
    logic [7:0]            rx_sh;
    logic [7:0]            rx_data;
    logic [15:0]           rx_cnt;
    logic [3:0]            rx_bits;
    logic                  idle_armed;
    logic                  txd;
    logic                  txd_oe_n;
    logic                  irq;
  } asl_state_t;

  asl_state_t r;
  asl_state_t n;

  logic                  req;
  logic                  hit;
  logic                  do_write;
  logic [2:0]            idx;
  logic                  loop_sel;
  logic                  src_sel;
  logic                  tx_on;
  logic                  rx_on;
  logic                  single_wire;
  logic                  rx_in;
  logic [15:0]           bit_last;
  logic [15:0]           bit_half;
  logic [ASL_NUM_EV-1:0] gate;
  logic [ASL_NUM_EV-1:0] ev;
  logic [ASL_NUM_EV-1:0] clr;
  logic                  pre_taken;
  logic [31:0]           rd_mux;

  assign req         = avs_read | avs_write;
  assign hit         = (avs_address[4:3] == 2'b00);
  assign do_write    = avs_write & ~r.wait_r & hit;
  assign idx         = avs_address[2:0];
  assign loop_sel    = r.ctrl_one[ASL_C1_LOOP_BIT];
  assign src_sel     = r.ctrl_one[ASL_C1_RX_SOURCE_SEL_BIT];
  assign tx_on       = r.ctrl_two[ASL_C2_TX_ON];
  assign rx_on       = r.ctrl_two[ASL_C2_RX_ON];
  assign single_wire = loop_sel & src_sel;
  assign bit_last    = (r.baud > 16'h0002) ? r.baud - 16'h0001 : 16'h0001;
  assign bit_half    = {1'b0, bit_last[15:1]};

  // Receiver source selection
  always_comb begin
    if (!loop_sel) begin
      rx_in = r.filt[0];
    end else if (src_sel) begin
      rx_in = r.filt[1];
    end else begin
      rx_in = r.tx_sh[0];
    end
  end

  // Enable gating per status bit
  assign gate[ASL_ST_TX_EMPTY] = r.ctrl_two[ASL_C2_TX_EMPTY_IE];
  assign gate[ASL_ST_TX_DONE]  = r.ctrl_two[ASL_C2_TX_DONE_IE];
  assign gate[ASL_ST_RX_FULL]  = r.ctrl_two[ASL_C2_RX_FULL_IE];
  assign gate[ASL_ST_OVERRUN]  = r.ctrl_two[ASL_C2_RX_FULL_IE];
  assign gate[ASL_ST_IDLE]     = r.ctrl_two[ASL_C2_IDLE_IE];

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      ASL_IDX_CTRL_ONE: rd_mux[7:0]  = r.ctrl_one;
      ASL_IDX_BAUD:     rd_mux[15:0] = r.baud;
      ASL_IDX_DATA:     rd_mux[7:0]  = r.rx_data;
      ASL_IDX_CTRL_TWO: rd_mux[7:0]  = r.ctrl_two;
      ASL_IDX_STAT_ONE: rd_mux[ASL_NUM_EV-1:0] = r.status;
      ASL_IDX_STAT_TWO: begin
        rd_mux[ASL_S2_LINE_BIT] = rx_in;
        rd_mux[ASL_S2_BUSY_BIT] = (r.tx_st != ASL_TX_IDLE);
        rd_mux[ASL_S2_DIR_BIT]  = r.pin_dir;
      end
      ASL_IDX_IRQ_MASK: rd_mux[ASL_NUM_EV-1:0] = r.mask;
      default:          rd_mux = 32'h0000_0000;
    endcase
    // Addresses past the register bank read zero
    if (!hit) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_comb begin
    n         = r;
    ev        = '0;
    clr       = '0;
    pre_taken = 1'b0;

    // Bus handshake: one wait cycle, then the access completes
    if (req && r.wait_r) begin
      n.wait_r = 1'b0;
      n.rdata  = rd_mux;
    end else begin
      n.wait_r = 1'b1;
    end

    // Register writes
    if (do_write) begin
      case (idx)
        ASL_IDX_CTRL_ONE: begin
          if (avs_byteenable[0]) begin
            n.ctrl_one = avs_writedata[7:0] &
                         (8'h01 << ASL_C1_LOOP_BIT | 8'h01 << ASL_C1_RX_SOURCE_SEL_BIT);
          end
        end
        ASL_IDX_BAUD: begin
          if (avs_byteenable[0]) begin
            n.baud[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            n.baud[15:8] = avs_writedata[15:8];
          end
        end
        ASL_IDX_DATA: begin
          if (avs_byteenable[0] && !r.tx_buf_full) begin
            n.tx_buf      = avs_writedata[7:0];
            n.tx_buf_full = 1'b1;
          end
        end
        ASL_IDX_CTRL_TWO: begin
          if (avs_byteenable[0]) begin
            n.ctrl_two = avs_writedata[7:0] & ASL_C2_RW_MASK;
          end
        end
        ASL_IDX_STAT_ONE: begin
          if (avs_byteenable[0]) begin
            clr = avs_writedata[ASL_NUM_EV-1:0];
          end
        end
        ASL_IDX_STAT_TWO: begin
          if (avs_byteenable[0]) begin
            n.pin_dir = avs_writedata[ASL_S2_DIR_BIT];
          end
        end
        ASL_IDX_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            n.mask = avs_writedata[ASL_NUM_EV-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Pin synchronisers: change accepted once stages two and three agree
    for (int i = 0; i < 2; i++) begin
      n.sync[i] = {r.sync[i][1:0], (i == 0) ? rxd_i : txd_i};
      if (r.sync[i][1] == r.sync[i][2]) begin
        n.filt[i] = r.sync[i][2];
      end
    end

    // Transmitter
    n.tx_on_d = tx_on;
    case (r.tx_st)
      ASL_TX_IDLE: begin
        n.tx_cnt  = 16'h0000;
        n.tx_bits = 4'h0;
        if (tx_on) begin
          if (r.pre_pend) begin
            n.tx_sh   = ASL_SH_IDLE;
            pre_taken = 1'b1;
            n.tx_st   = ASL_TX_PRE;
          end else if (r.tx_buf_full) begin
            n.tx_sh       = {1'b1, r.tx_buf, 1'b0};
            n.tx_buf_full = 1'b0;
            ev[ASL_ST_TX_EMPTY] = 1'b1;
            n.tx_st       = ASL_TX_SHIFT;
          end
        end
      end
      ASL_TX_SHIFT, ASL_TX_PRE: begin
        if (r.tx_cnt == bit_last) begin
          n.tx_cnt  = 16'h0000;
          n.tx_sh   = {1'b1, r.tx_sh[9:1]};
          n.tx_bits = r.tx_bits + 4'h1;
          if (r.tx_bits == ASL_LAST_BIT) begin
            n.tx_bits = 4'h0;
            n.tx_st   = ASL_TX_IDLE;
            if (!n.tx_buf_full && !r.pre_pend) begin
              ev[ASL_ST_TX_DONE] = 1'b1;
            end
          end
        end else begin
          n.tx_cnt = r.tx_cnt + 16'h0001;
        end
      end
      default: begin
        n.tx_st = ASL_TX_IDLE;
        n.tx_sh = ASL_SH_IDLE;
      end
    endcase
    // Enable rising edge queues a preamble; a new edge beats the take
    n.pre_pend = (r.pre_pend & ~pre_taken) | (tx_on & ~r.tx_on_d);

    // Receiver
    case (r.rx_st)
      ASL_RX_IDLE: begin
        if (!rx_on) begin
          n.idle_armed = 1'b0;
          n.rx_cnt     = 16'h0000;
          n.rx_bits    = 4'h0;
        end else if (!rx_in) begin
          n.rx_st   = ASL_RX_START;
          n.rx_cnt  = 16'h0000;
          n.rx_bits = 4'h0;
        end else if (r.idle_armed) begin
          if (r.rx_cnt == bit_last) begin
            n.rx_cnt  = 16'h0000;
            n.rx_bits = r.rx_bits + 4'h1;
            if (r.rx_bits == ASL_LAST_BIT) begin
              ev[ASL_ST_IDLE] = 1'b1;
              n.idle_armed    = 1'b0;
              n.rx_bits       = 4'h0;
            end
          end else begin
            n.rx_cnt = r.rx_cnt + 16'h0001;
          end
        end
      end
      ASL_RX_START: begin
        if (!rx_on) begin
          n.rx_st = ASL_RX_IDLE;
        end else if (r.rx_cnt == bit_half) begin
          n.rx_cnt = 16'h0000;
          n.rx_st  = rx_in ? ASL_RX_IDLE : ASL_RX_DATA;
        end else begin
          n.rx_cnt = r.rx_cnt + 16'h0001;
        end
      end
      ASL_RX_DATA: begin
        if (!rx_on) begin
          n.rx_st = ASL_RX_IDLE;
        end else if (r.rx_cnt == bit_last) begin
          n.rx_cnt  = 16'h0000;
          n.rx_bits = r.rx_bits + 4'h1;
          if (r.rx_bits == ASL_STOP_BIT) begin
            n.rx_st      = ASL_RX_IDLE;
            n.rx_bits    = 4'h0;
            n.idle_armed = 1'b1;
            if (rx_in) begin
              if (r.status[ASL_ST_RX_FULL]) begin
                ev[ASL_ST_OVERRUN] = 1'b1;
              end else begin
                n.rx_data          = r.rx_sh;
                ev[ASL_ST_RX_FULL] = 1'b1;
              end
            end
          end else begin
            n.rx_sh = {rx_in, r.rx_sh[7:1]};
          end
        end else begin
          n.rx_cnt = r.rx_cnt + 16'h0001;
        end
      end
      default: begin
        n.rx_st = ASL_RX_IDLE;
      end
    endcase

    // Sticky status: a new event wins over a clear in the same cycle
    n.status = (r.status & ~clr) | ev;

    // Pin drive
    n.txd = r.tx_sh[0];
    if (!tx_on) begin
      n.txd_oe_n = 1'b1;
    end else if (single_wire) begin
      n.txd_oe_n = ~r.pin_dir;
    end else begin
      n.txd_oe_n = 1'b0;
    end

    n.irq = |(r.status & gate & r.mask);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r             <= '0;
      r.wait_r      <= 1'b1;
      r.ctrl_one    <= ASL_C1_RST;
      r.ctrl_two    <= ASL_C2_RST;
      r.baud        <= ASL_BAUD_RST;
      r.mask        <= ASL_MASK_RST;
      r.sync        <= '1;
      r.filt        <= 2'b11;
      r.tx_st       <= ASL_TX_IDLE;
      r.tx_sh       <= ASL_SH_IDLE;
      r.rx_st       <= ASL_RX_IDLE;
      r.txd         <= 1'b1;
      r.txd_oe_n    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.wait_r;
  assign txd_o           = r.txd;
  assign txd_oe_n        = r.txd_oe_n;
  assign irq             = r.irq;

endmodule

`default_nettype wire

// File: asl_chk_assertions.sv
// Port-level checker for the serial control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module asl_chk
  import asl_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and interrupt
  input wire logic        rxd_i,
  input wire logic        txd_i,
  input wire logic        txd_o,
  input wire logic        txd_oe_n,
  input wire logic        irq
);
  logic [7:0]  c1_r, c2_r, c2_q;
  logic [15:0] baud_r;
  logic [19:0] pre_r;
  logic [1:0]  sw_q;
  logic        dir_r, wr_w, sw_w;
  assign wr_w = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[4:3] == 2'b00;
  assign sw_w = c1_r[7] && c1_r[5] && c2_r[3];
  // Register shadows, taken at the completing edge of each write
  always_ff @(posedge clk) begin
    c2_q <= c2_r;
    sw_q <= {sw_w, dir_r};
    if (sys_rst) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
      dir_r <= 1'b0;
      baud_r <= ASL_BAUD_RST;
      pre_r <= 20'h0;
    end else begin
      if (wr_w && avs_address[2:0] == ASL_IDX_CTRL_ONE) c1_r <= avs_writedata[7:0];
      if (wr_w && avs_address[2:0] == ASL_IDX_CTRL_TWO) c2_r <= avs_writedata[7:0] & 8'hFC;
      if (wr_w && avs_address[2:0] == ASL_IDX_STAT_TWO) dir_r <= avs_writedata[1];
      if (wr_w && avs_address[2:0] == ASL_IDX_BAUD) baud_r <= avs_writedata[15:0];
      // Idle preamble window after the transmitter is switched on
      if (c2_r[3] && !c2_q[3]) pre_r <= 20'(baud_r) * 20'd10;
      else if (pre_r != 20'h0) pre_r <= pre_r - 20'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_one_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  wait_one_a: assert property (s_taken |=> s_one_ack)
    else $error("bus ack not one cycle");
  bus_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest
    |=> avs_waitrequest)
    else $error("ack without request");
  ctrl_two_read_a: assert property (avs_read && !avs_waitrequest
    && avs_address == {2'b00, ASL_IDX_CTRL_TWO} |-> avs_readdata == {24'h0, c2_r})
    else $error("control two readback wrong");
  tx_off_oe_a: assert property (!c2_r[3] && !c2_q[3] |-> txd_oe_n)
    else $error("pin driven with transmitter off");
  pin_dir_a: assert property (sw_w && sw_q == {sw_w, dir_r} |-> txd_oe_n == !dir_r)
    else $error("single wire direction wrong");
  irq_gate_a: assert property (c2_r[7:4] == 4'h0 && c2_q[7:4] == 4'h0 |-> !irq)
    else $error("interrupt with all gates off");
  preamble_high_a: assert property (pre_r != 20'h0 |-> txd_o)
    else $error("line low during preamble");
  irq_fall_a: assert property ($fell(c2_r[5]) && c2_r[7:4] == 4'h0 |=> ##1 !irq)
    else $error("interrupt kept after gate cleared");
endmodule
bind asl_serial_ctrl asl_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd_i(rxd_i),
  .txd_i(txd_i), .txd_o(txd_o), .txd_oe_n(txd_oe_n), .irq(irq));
`default_nettype wire

// File: asl_peer.sv
// Far-end serial device: sends 8N1 frames on the receive line or the shared wire.
// Assumes the bench calls send right after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module asl_peer (
  // Clock
  input  wire logic clk,
  // Holds the receive line low when set
  input  wire logic jam,
  // Serial lines
  output logic      rxd_line,
  output logic      wire_val,
  output logic      wire_en
);
  logic line_r = 1'b1;
  assign rxd_line = jam ? 1'b0 : line_r;
  initial begin
    wire_val = 1'b1;
    wire_en = 1'b0;
  end
  task automatic send(input logic [7:0] b, input int baud, input logic on_wire);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      wire_en <= on_wire;
      wire_val <= f[i];
      if (!on_wire) line_r <= f[i];
      repeat (baud) @(posedge clk);
    end
    // Release: the shared wire falls back to its pull-up
    wire_en <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the serial control block and its far-end peer.
// Assumes a 50 MHz clock and a pull-up on the shared transmit wire.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import asl_pkg::*;
;
  logic        clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, jam = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d, seed = 32'h6E748C68;
  logic        avs_waitrequest, txd_i, txd_o, txd_oe_n, irq, rxd_line, wire_val, wire_en;
  logic [7:0]  b;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  always #10 clk = ~clk;
  assign txd_i = !txd_oe_n ? txd_o : (wire_en ? wire_val : 1'b1);
  asl_serial_ctrl u_dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd_i(rxd_line),
    .txd_i(txd_i), .txd_o(txd_o), .txd_oe_n(txd_oe_n), .irq(irq));
  asl_peer u_peer (
    .clk(clk), .jam(jam), .rxd_line(rxd_line), .wire_val(wire_val), .wire_en(wire_en));
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] gate(input int g);
    return g == 4 ? 8'h00 : (g == 5 ? 8'hF0 : 8'h80 >> g);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= {2'b00, idx};
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, ASL_IDX_STAT_ONE, 32'h0);
      n++;
    end while ((d[7:0] & m) == 8'h0 && n < 200);
    if ((d[7:0] & m) == 8'h0) begin
      bad_count++;
      $display("Error at %0t: flag wait limit reached", $time);
    end
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, ASL_IDX_CTRL_TWO, 32'h0);
    check(d, 32'h0);
    bus(1'b0, 3'h7, 32'h0);
    check(d, 32'h0);
    check(txd_oe_n, 1'b1);
    bus(1'b1, ASL_IDX_BAUD, 32'h4);
    for (int i = 0; i < 4; i++) begin
      b = xs();
      bus(1'b1, ASL_IDX_CTRL_TWO, {24'h0, b});
      bus(1'b0, ASL_IDX_CTRL_TWO, 32'h0);
      check(d, {24'h0, b & ASL_C2_RW_MASK});
    end
    // Pin receive with the source bit both ways
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, ASL_IDX_CTRL_ONE, {26'h0, s[0], 5'h0});
      bus(1'b1, ASL_IDX_CTRL_TWO, 32'h24);
      bus(1'b1, ASL_IDX_STAT_ONE, 32'h1F);
      b = xs();
      u_peer.send(b, 4, 1'b0);
      poll(8'h04);
      settle();
      check(irq, 1'b1);
      bus(1'b0, ASL_IDX_DATA, 32'h0);
      check(d[7:0], b);
      bus(1'b1, ASL_IDX_STAT_ONE, 32'h1F);
      settle();
      check(irq, 1'b0);
    end
    bus(1'b1, ASL_IDX_CTRL_TWO, 32'h20);
    u_peer.send(xs(), 4, 1'b0);
    repeat (10) @(posedge clk);
    bus(1'b0, ASL_IDX_STAT_ONE, 32'h0);
    check(d[2], 1'b0);
    // Internal loop, receive pin jammed low; each gate alone, none, then masked
    jam <= 1'b1;
    bus(1'b1, ASL_IDX_CTRL_ONE, 32'h80);
    for (int g = 0; g < 6; g++) begin
      bus(1'b1, ASL_IDX_STAT_ONE, 32'h1F);
      bus(1'b1, ASL_IDX_IRQ_MASK, g == 5 ? 32'h0 : 32'h1F);
      bus(1'b1, ASL_IDX_CTRL_TWO, {24'h0, gate(g) | 8'h0C});
      b = xs();
      bus(1'b1, ASL_IDX_DATA, {24'h0, b});
      if (g == 0) begin
        repeat (3) @(negedge clk);
        check(txd_o, 1'b1);
      end
      poll(8'h01);
      check(d[4:0], 5'h1D);
      bus(1'b0, ASL_IDX_DATA, 32'h0);
      check(d[7:0], b);
      settle();
      check(irq, g < 4);
    end
    // Back-to-back bytes: second frame overruns
    bus(1'b1, ASL_IDX_IRQ_MASK, 32'h1F);
    bus(1'b1, ASL_IDX_CTRL_TWO, 32'h2C);
    bus(1'b1, ASL_IDX_STAT_ONE, 32'h1F);
    bus(1'b1, ASL_IDX_DATA, 32'h5A);
    bus(1'b1, ASL_IDX_DATA, 32'hA5);
    poll(8'h02);
    bus(1'b0, ASL_IDX_DATA, 32'h0);
    check(d[7:0], 8'h5A);
    bus(1'b1, ASL_IDX_STAT_ONE, 32'h1D);
    settle();
    check(irq, 1'b1);
    // Single wire: peer talks on the transmit pin
    bus(1'b1, ASL_IDX_STAT_ONE, 32'h1F);
    bus(1'b1, ASL_IDX_STAT_TWO, 32'h0);
    bus(1'b1, ASL_IDX_CTRL_ONE, 32'hA0);
    settle();
    check(txd_oe_n, 1'b1);
    b = xs();
    u_peer.send(b, 4, 1'b1);
    poll(8'h04);
    bus(1'b0, ASL_IDX_DATA, 32'h0);
    check(d[7:0], b);
    bus(1'b1, ASL_IDX_STAT_TWO, 32'h2);
    settle();
    check(txd_oe_n, 1'b0);
    bus(1'b0, ASL_IDX_STAT_TWO, 32'h0);
    check(d[1], 1'b1);
    check(d[7], 1'b1);
    bus(1'b1, ASL_IDX_CTRL_ONE, 32'h0);
    settle();
    check(txd_oe_n, 1'b0);
    bus(1'b1, ASL_IDX_CTRL_TWO, 32'h0);
    settle();
    check(txd_oe_n, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
